// ===== hdl/lsc_pkg.sv
// Purpose: constants and types for the light sensor control and interrupt block
// Assumes: 200 MHz system clock, registers on a plain strobe port
// Notes:   register offsets are byte addresses of 32-bit words
//
// What this block does
// R1: every light measurement is a 16-, 12-, 8- or 4-bit result of the charge-balancing converter, by resolution
// R2: conversion lasts 105 ms at full resolution, down to 11 us when reduced
// R3: single-measurement mode powers down automatically after each conversion
// R4: a second power-down state is entered and left only by host command
// R5: brownout flag is set at power-up and held until the host clears it
// R6: interrupt flag and output stay asserted until the host clears the flag
// R7: conversions keep running while the interrupt is asserted
// R8: interrupt pin is pulled low by an open-drain driver, released otherwise
// R9: host selects a lux range that changes counts per lux
// R10: results compared to host thresholds, persistence filter before interrupt
// R11: a result outside the low/high window qualifies; inside resets persistence
// R12: interrupt flag rises at the end of the qualifying conversion only
package lsc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned T_CONV_MS   = 105;
    localparam int unsigned T_MIN_US    = 11;
    localparam int unsigned CONV_CYC    = (CLK_HZ / 1000) * T_CONV_MS;
    localparam int unsigned MIN_CYC     = (CLK_HZ / 1_000_000) * T_MIN_US;
    localparam int unsigned RES_BITS    = 16;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STAT   = 8'h04;
    localparam logic [7:0]  ADDR_MASK   = 8'h08;
    localparam logic [7:0]  ADDR_DATA   = 8'h0C;
    localparam logic [7:0]  ADDR_THLO   = 8'h10;
    localparam logic [7:0]  ADDR_THHI   = 8'h14;

    // ctrl fields: mode [1:0], lux range [3:2], resolution [5:4], persistence [7:6]
    localparam int unsigned CTRL_MODE   = 0;
    localparam int unsigned CTRL_RNG    = 2;
    localparam int unsigned CTRL_RES    = 4;
    localparam int unsigned CTRL_PERS   = 6;

    // status bits
    localparam int unsigned ST_BROWN    = 0;
    localparam int unsigned ST_THR      = 1;
    localparam int unsigned ST_DONE     = 2;

    // reset values
    localparam logic [2:0]  STAT_RST    = 3'h1;
    localparam logic [2:0]  MASK_RST    = 3'h2;
    localparam logic [15:0] THLO_RST    = 16'h0000;
    localparam logic [15:0] THHI_RST    = 16'hFFFF;

    typedef enum logic [1:0] {
        MODE_OFF  = 2'b00,
        MODE_ONCE = 2'b01,
        MODE_CONT = 2'b10,
        MODE_RSV  = 2'b11
    } mode_t;

    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_CONV = 1'b1
    } fsm_t;

    // qualifying results needed for each persistence setting
    function automatic logic [4:0] persist_need(input logic [1:0] sel);
        case (sel)
            2'b00:   persist_need = 5'h01;
            2'b01:   persist_need = 5'h04;
            2'b10:   persist_need = 5'h08;
            default: persist_need = 5'h10;
        endcase
    endfunction : persist_need

endpackage : lsc_pkg

// ===== hdl/conv_if.sv
// Purpose: link between the control logic and the converter engine
// Assumes: one clock domain
// Notes:   start and done are one-cycle pulses
`timescale 1ns/1ps
interface conv_if;
    logic        start;
    logic        light;
    logic [1:0]  res_sel;
    logic [1:0]  lux_rng;
    logic        done;
    logic [15:0] result;

    modport ctl (output start, light, res_sel, lux_rng, input done, result);
    modport eng (input start, light, res_sel, lux_rng, output done, result);
endinterface : conv_if

// ===== hdl/conv_engine.sv
// Purpose: charge-balancing conversion counter
// Assumes: light is a one-cycle pulse per charge packet, already synchronised
// Notes:   range and resolution are sampled only while idle
`timescale 1ns/1ps
module conv_engine #(
    parameter int unsigned CONV_CYCLES = lsc_pkg::CONV_CYC
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    conv_if.eng       c
);
    import lsc_pkg::*;

    typedef struct packed {
        logic        busy;
        logic [31:0] cyc;
        logic [5:0]  pre;
        logic [1:0]  rng;
        logic [1:0]  res;
        logic [15:0] acc;
        logic        done;
        logic [15:0] result;
    } eng_st_t;

    eng_st_t st_ff;
    eng_st_t nxt_st;
    logic [5:0]  div_mask;
    logic [15:0] full;
    logic [31:0] per;

    // ----------------------------------------------------------------
    // conversion sequencing
    // ----------------------------------------------------------------
    // each resolution step drops four bits and cuts the period by 16
    assign per      = 32'(CONV_CYCLES >> {c.res_sel, 2'b00});              // [R2]
    // a higher lux range needs more charge packets per count
    assign div_mask = 6'((7'h01 << {st_ff.rng, 1'b0}) - 7'h01);            // [R9]
    assign full     = 16'((17'h1_0000 >> {st_ff.res, 2'b00}) - 17'h0_0001);

    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        if (!st_ff.busy)
        begin
            if (c.start)
            begin
                nxt_st.busy = 1'b1;
                // floor keeps the shortest period at the documented minimum
                nxt_st.cyc  = (per < MIN_CYC) ? MIN_CYC : per;             // [R2]
                nxt_st.pre  = 6'h00;
                nxt_st.acc  = 16'h0000;
                nxt_st.rng  = c.lux_rng;
                nxt_st.res  = c.res_sel;
            end
        end
        else
        begin
            if (c.light)
            begin
                if (st_ff.pre == div_mask)
                begin
                    nxt_st.pre = 6'h00;
                    if (st_ff.acc != full)
                        nxt_st.acc = st_ff.acc + 16'h0001;                 // [R1]
                end
                else
                    nxt_st.pre = st_ff.pre + 6'h01;
            end
            if (st_ff.cyc == 32'h0000_0001)
            begin
                nxt_st.busy   = 1'b0;
                nxt_st.done   = 1'b1;
                nxt_st.result = st_ff.acc;                                 // [R1]
            end
            else
                nxt_st.cyc = st_ff.cyc - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign c.done   = st_ff.done;
    assign c.result = st_ff.result;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    start_busy_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R2]
        (c.start && !st_ff.busy) |=> (st_ff.busy && !st_ff.done) [*2])
        else $error("conversion did not start or ended too early");
    result_sat_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R1]
        c.done |-> (c.result <= full))
        else $error("result exceeds resolution full scale");

endmodule : conv_engine

// ===== hdl/light_sensor_ctrl.sv
// Purpose: control, result compare and interrupt logic of the light sensor
// Assumes: light_pulse_i comes from the analog charge balancer, asynchronous
// Notes:   int pin is open drain: int_o is always low, int_oe_o pulls the line
`timescale 1ns/1ps
module light_sensor_ctrl #(
    parameter int unsigned CONV_CYCLES = lsc_pkg::CONV_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        light_pulse_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    output logic             int_o,
    output logic             int_oe_o
);
    import lsc_pkg::*;

    typedef struct packed {
        logic [31:0] rdata;
        mode_t       mode;
        logic [1:0]  rng;
        logic [1:0]  res;
        logic [1:0]  pers;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic [15:0] thlo;
        logic [15:0] thhi;
        logic [15:0] data;
        logic [4:0]  pcnt;
        fsm_t        fsm;
        logic        start;
        logic        irq;
    } ctl_st_t;

    ctl_st_t     st_ff;
    ctl_st_t     nxt_st;
    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    logic [2:0]  light_sync_ff;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        outside;
    logic [2:0]  set_ev;
    logic [31:0] len_ff;
    logic [1:0]  len_res_ff;
    logic [31:0] len_per;
    logic [31:0] len_exp;

    conv_if c ();

    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    // reset asserts at once but releases only after two clean edges
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_sync_ff <= 2'b00;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    // stage 0 only feeds stage 1; the edge detector uses stages 1 and 2
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            light_sync_ff <= 3'b000;
        else
            light_sync_ff <= {light_sync_ff[1:0], light_pulse_i};
    end

    // ----------------------------------------------------------------
    // converter
    // ----------------------------------------------------------------
    assign c.start   = st_ff.start;
    assign c.light   = light_sync_ff[1] & ~light_sync_ff[2];
    assign c.res_sel = st_ff.res;
    assign c.lux_rng = st_ff.rng;                                          // [R9]

    conv_engine #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_engine (
        .clk_i  (clk_i),
        .nrst_i (rst_n),
        .c      (c)
    );

    // ----------------------------------------------------------------
    // control, compare and registers
    // ----------------------------------------------------------------
    assign wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
    assign wr_stat = wr_i && (addr_i == ADDR_STAT);
    // window compare; equal to a threshold counts as inside
    assign outside = (c.result < st_ff.thlo) || (c.result > st_ff.thhi);   // [R11]

    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.start = 1'b0;
        set_ev       = 3'b000;

        // sequencer: the interrupt never stalls the next conversion
        case (st_ff.fsm)
            S_IDLE:
            begin
                if (st_ff.mode == MODE_ONCE || st_ff.mode == MODE_CONT)    // [R7]
                begin
                    nxt_st.start = 1'b1;
                    nxt_st.fsm   = S_CONV;
                end
            end
            S_CONV:
            begin
                if (c.done)
                begin
                    nxt_st.fsm  = S_IDLE;
                    nxt_st.data = c.result;                                // [R1]
                    set_ev[ST_DONE] = 1'b1;
                    // single shot: the mode field goes back to power-down
                    if (st_ff.mode == MODE_ONCE)
                        nxt_st.mode = MODE_OFF;                            // [R3]
                    // persistence counts only completed conversions
                    if (outside)
                    begin
                        if (st_ff.pcnt + 5'h01 >= persist_need(st_ff.pers))
                        begin
                            set_ev[ST_THR] = 1'b1;                         // [R10] [R12]
                            nxt_st.pcnt    = persist_need(st_ff.pers);
                        end
                        else
                            nxt_st.pcnt = st_ff.pcnt + 5'h01;              // [R10]
                    end
                    else
                        nxt_st.pcnt = 5'h00;                               // [R11]
                end
            end
            default:
                nxt_st.fsm = S_IDLE;
        endcase

        // host writes; mode off is the software power-down state
        if (wr_ctrl)
        begin
            nxt_st.mode = mode_t'(wdata_i[CTRL_MODE +: 2]);                // [R4]
            nxt_st.rng  = wdata_i[CTRL_RNG +: 2];                          // [R9]
            nxt_st.res  = wdata_i[CTRL_RES +: 2];
            nxt_st.pers = wdata_i[CTRL_PERS +: 2];
        end
        if (wr_i && addr_i == ADDR_MASK)
            nxt_st.mask = wdata_i[2:0];
        if (wr_i && addr_i == ADDR_THLO)
            nxt_st.thlo = wdata_i[15:0];
        if (wr_i && addr_i == ADDR_THHI)
            nxt_st.thhi = wdata_i[15:0];

        // sticky flags: write one clears, a same-cycle event wins
        nxt_st.status = (st_ff.status & ~(wr_stat ? wdata_i[2:0] : 3'b000))
                        | set_ev;                                          // [R5] [R6]
        nxt_st.irq    = |(nxt_st.status & st_ff.mask);                     // [R6]

        // read data valid in the cycle after the strobe only
        nxt_st.rdata = 32'h0000_0000;
        if (rd_i)
        begin
            case (addr_i)
                ADDR_CTRL: nxt_st.rdata = {24'h00_0000, st_ff.pers, st_ff.res,
                                           st_ff.rng, st_ff.mode};
                ADDR_STAT: nxt_st.rdata = {29'h0000_0000, st_ff.status};
                ADDR_MASK: nxt_st.rdata = {29'h0000_0000, st_ff.mask};
                ADDR_DATA: nxt_st.rdata = {16'h0000, st_ff.data};
                ADDR_THLO: nxt_st.rdata = {16'h0000, st_ff.thlo};
                ADDR_THHI: nxt_st.rdata = {16'h0000, st_ff.thhi};
                default:   nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // brownout bit comes up set on every power-up reset
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff        <= '0;
            st_ff.mode   <= MODE_OFF;
            st_ff.fsm    <= S_IDLE;
            st_ff.status <= STAT_RST;                                      // [R5]
            st_ff.mask   <= MASK_RST;
            st_ff.thlo   <= THLO_RST;
            st_ff.thhi   <= THHI_RST;
        end
        else
            st_ff <= nxt_st;
    end

    assign rdata_o  = st_ff.rdata;
    // open drain: only ever drive low, release otherwise
    assign int_o    = 1'b0;                                                // [R8]
    assign int_oe_o = st_ff.irq;                                           // [R8]

    // ----------------------------------------------------------------
    // conversion length watch
    // ----------------------------------------------------------------
    // helper for the checks only; it keeps the resolution seen at the
    // start pulse, since the host may rewrite it while a conversion runs
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            len_ff     <= 32'h0000_0000;
            len_res_ff <= 2'b00;
        end
        else if (c.start)
        begin
            len_ff     <= 32'h0000_0001;
            len_res_ff <= st_ff.res;
        end
        else
            len_ff <= len_ff + 32'h0000_0001;
    end

    // four bits less per resolution step, never below the shortest period
    assign len_per = CONV_CYCLES >> {len_res_ff, 2'b00};
    assign len_exp = (len_per < MIN_CYC) ? MIN_CYC : len_per;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence once_done_s;
        c.done && st_ff.fsm == S_CONV && st_ff.mode == MODE_ONCE && !wr_ctrl;
    endsequence
    sequence cont_done_s;
        c.done && st_ff.fsm == S_CONV && st_ff.mode == MODE_CONT && !wr_ctrl;
    endsequence

    auto_pd_a: assert property (once_done_s |=> st_ff.mode == MODE_OFF) // [R3]
        else $error("single mode did not power down after conversion");
    cont_run_a: assert property (cont_done_s |-> ##2 c.start) // [R7]
        else $error("continuous mode did not restart conversion");
    off_idle_a: assert property ( // [R4]
        (st_ff.mode == MODE_OFF && st_ff.fsm == S_IDLE && !wr_ctrl) |=> !c.start)
        else $error("conversion started while powered down");
    brown_hold_a: assert property ( // [R5]
        (st_ff.status[ST_BROWN] && !(wr_stat && wdata_i[ST_BROWN]))
        |=> st_ff.status[ST_BROWN])
        else $error("brownout flag lost without host clear");
    irq_hold_a: assert property ( // [R6]
        (st_ff.status[ST_THR] && !(wr_stat && wdata_i[ST_THR]))
        |=> st_ff.status[ST_THR])
        else $error("interrupt flag lost without host clear");
    int_pin_a: assert property ( // [R8]
        (st_ff.status[ST_THR] && st_ff.mask[ST_THR] && !(wr_stat && wdata_i[ST_THR]))
        |=> int_oe_o && !int_o)
        else $error("interrupt pin not pulled low");
    thr_edge_a: assert property ($rose(st_ff.status[ST_THR]) |-> $past(c.done)) // [R12]
        else $error("interrupt flag rose outside conversion end");
    win_reset_a: assert property ( // [R11]
        (c.done && st_ff.fsm == S_CONV && !outside) |=> st_ff.pcnt == 5'h00)
        else $error("persistence not reset inside window");
    persist_a: assert property ( // [R10]
        (c.done && st_ff.fsm == S_CONV && outside
         && st_ff.pcnt + 5'h01 < persist_need(st_ff.pers)
         && !st_ff.status[ST_THR]) |=> !st_ff.status[ST_THR])
        else $error("interrupt raised before persistence met");
    data_cap_a: assert property ( // [R1]
        (c.done && st_ff.fsm == S_CONV) |=> st_ff.data == $past(c.result))
        else $error("result not captured");
    conv_len_a: assert property ( // [R2]
        (c.done && st_ff.fsm == S_CONV) |-> len_ff == len_exp + 32'h0000_0001)
        else $error("conversion period differs from resolution setting");
    // positive side of the persistence filter
    thr_set_a: assert property ( // [R10]
        (c.done && st_ff.fsm == S_CONV && outside
         && st_ff.pcnt + 5'h01 >= persist_need(st_ff.pers)) |=> st_ff.status[ST_THR])
        else $error("interrupt not raised once persistence met");
    int_release_a: assert property ( // [R8]
        ((st_ff.status & st_ff.mask) == 3'b000 && set_ev == 3'b000) |=> !int_oe_o)
        else $error("interrupt pin pulled with nothing pending");
    done_flag_a: assert property ( // [R12]
        (c.done && st_ff.fsm == S_CONV) |=> st_ff.status[ST_DONE])
        else $error("done flag not set at conversion end");
    rsv_idle_a: assert property ( // [R4]
        (st_ff.mode == MODE_RSV && st_ff.fsm == S_IDLE && !wr_ctrl) |=> !c.start)
        else $error("conversion started in the reserved mode");
    // register side: read-only result and status readback
    data_ro_a: assert property ( // [R1]
        (wr_i && addr_i == ADDR_DATA && !(c.done && st_ff.fsm == S_CONV))
        |=> $stable(st_ff.data))
        else $error("result register changed by a host write");
    stat_read_a: assert property ( // [R5]
        (rd_i && addr_i == ADDR_STAT) |=> rdata_o == {29'h0000_0000, $past(st_ff.status)})
        else $error("status read back wrong");

endmodule : light_sensor_ctrl

// ===== dv/host_model.sv
// Purpose: host side of the register port, issuing single-cycle strobes
// Assumes: one clock, strobes launched by non-blocking assignment after an edge
// Notes:   read data is taken in the cycle after the read strobe only
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] rdata_i,
    output logic [7:0]       addr_o,
    output logic [31:0]      wdata_o,
    output logic             wr_o,
    output logic             rd_o
);
    // ------------------------------------------------------------
    // bus idle values
    // ------------------------------------------------------------
    initial
    begin
        addr_o  = 8'hFF;
        wdata_o = 32'h0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // one write cycle; commands and flag clears all go through here
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_o    <= 1'b1;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d; // no stale data left on an idle bus
    endtask : reg_wr

    // one read cycle, data sampled at the following edge
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_o   <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        @(posedge clk_i);
        d = rdata_i;
    endtask : reg_rd
endmodule : host_model

// ===== dv/test_light_sensor_control_irq.sv
// Purpose: self-checking bench for the light sensor control and interrupt block
// Assumes: shortened conversion period, 12-bit resolution except the floor pass
// Notes:   light packets are sent only inside a conversion so counts are exact
`timescale 1ns/1ps
module test_light_sensor_control_irq;
    import lsc_pkg::*;

    localparam int unsigned CONV = 40000;
    localparam logic [1:0]  RES  = 2'h1; // 12 bits, 2500 cycles a conversion

    logic        clk;
    logic        nrst;
    logic        light;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        int_pin;
    logic        int_oe;
    int          err_total;
    int          n_tests;
    int          pc;
    logic        irq_exp;
    logic [31:0] d;
    logic [1:0]  res_cur;

    // ------------------------------------------------------------
    // design, host and clock
    // ------------------------------------------------------------
    light_sensor_ctrl #(.CONV_CYCLES(CONV)) u_dut (
        .clk_i(clk), .nrst_i(nrst), .light_pulse_i(light), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .int_o(int_pin), .int_oe_o(int_oe));

    host_model u_host (
        .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [1:0] r,
                                         input logic [1:0] p);
        ctrl = {24'h0, p, res_cur, r, m};
    endfunction : ctrl

    // poll until a conversion completes, then clear its done flag
    task automatic wait_done();
        logic [31:0] s;
        for (int i = 0; i < 2000; i++)
        begin
            u_host.reg_rd(ADDR_STAT, s);
            if (s[ST_DONE] === 1'b1)
            begin
                u_host.reg_wr(ADDR_STAT, 32'h4);
                return;
            end
        end
        err_total++;
        stop_test();
    endtask : wait_done

    // single conversion with n packets; packets stay within the conversion window
    task automatic conv_once(input int n, input logic [1:0] r, input logic [1:0] p);
        u_host.reg_wr(ADDR_CTRL, ctrl(MODE_ONCE, r, p));
        repeat (10) @(posedge clk);
        repeat (n)
        begin
            light <= 1'b1;
            repeat (2) @(posedge clk);
            light <= 1'b0;
            repeat (2) @(posedge clk);
        end
        wait_done();
    endtask : conv_once

    initial
    begin
        repeat (90000) @(posedge clk);
        err_total++;
        stop_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0]  ra [7];
        logic [31:0] rv [7];
        int          n;
        int          ns [7];
        int          e;
        err_total = 0;
        n_tests   = 0;
        light     = 1'b0;
        res_cur   = RES;
        nrst      = 1'b0;
        void'($urandom(67424));
        ra = '{ADDR_CTRL, ADDR_STAT, ADDR_MASK, ADDR_DATA, ADDR_THLO, ADDR_THHI, 8'h20};
        rv = '{32'h0, 32'h1, 32'h2, 32'h0, 32'h0, 32'hFFFF, 32'h0};
        ns = '{200, 5, 50, 200, 5, 200, 200};
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values, unmapped place, read-only data
        u_host.reg_wr(ADDR_DATA, 32'h1234);
        for (int i = 0; i < 7; i++)
        begin
            u_host.reg_rd(ra[i], d);
            check("reset reg", d, rv[i]);
        end
        check("int level", {31'h0, int_pin}, 32'h0);
        check("int drive", {31'h0, int_oe}, 32'h0);
        // brownout unmasked pulls the pin until cleared
        u_host.reg_wr(ADDR_MASK, 32'h3);
        repeat (3) @(posedge clk);
        check("brownout int", {31'h0, int_oe}, 32'h1);
        u_host.reg_wr(ADDR_STAT, 32'h1);
        repeat (3) @(posedge clk);
        check("brownout clr", {31'h0, int_oe}, 32'h0);
        u_host.reg_wr(ADDR_MASK, 32'h2);
        // every lux range, auto power-down after each single conversion
        for (int r = 0; r < 4; r++)
        begin
            n = $urandom_range(500, 0);
            e = n >> (2 * r);
            conv_once(n, r[1:0], 2'h0);
            u_host.reg_rd(ADDR_DATA, d);
            check("data", d, (e > 4095) ? 32'hFFF : 32'(e));
            u_host.reg_rd(ADDR_CTRL, d);
            check("auto off", d, ctrl(MODE_OFF, r[1:0], 2'h0));
        end
        // low resolutions: shortest period floor, result saturates at full scale
        for (int s = 2; s < 4; s++)
        begin
            res_cur = s[1:0];
            e       = (1 << (16 - 4 * s)) - 1;
            conv_once(300, 2'h0, 2'h0);
            u_host.reg_rd(ADDR_DATA, d);
            check("saturate", d, (e < 300) ? 32'(e) : 32'h0000_012C);
        end
        res_cur = RES;
        // window and persistence of four against the model
        u_host.reg_wr(ADDR_THLO, 32'd20);
        u_host.reg_wr(ADDR_THHI, 32'd100);
        pc      = 0;
        irq_exp = 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            conv_once(ns[i], 2'h0, 2'h1);
            pc = (ns[i] < 20 || ns[i] > 100) ? ((pc < 4) ? pc + 1 : 4) : 0;
            irq_exp = irq_exp | (pc >= 4);
            check("persist int", {31'h0, int_oe}, {31'h0, irq_exp});
        end
        // continuous runs on with the interrupt held
        u_host.reg_wr(ADDR_CTRL, ctrl(MODE_CONT, 2'h0, 2'h1));
        wait_done();
        wait_done();
        check("int held", {31'h0, int_oe}, 32'h1);
        // software power-down: current conversion ends, no restart
        u_host.reg_wr(ADDR_CTRL, ctrl(MODE_OFF, 2'h0, 2'h1));
        wait_done();
        // the reserved mode code must stay powered down as well
        u_host.reg_wr(ADDR_CTRL, ctrl(MODE_RSV, 2'h0, 2'h1));
        repeat (3000) @(posedge clk);
        u_host.reg_rd(ADDR_STAT, d);
        check("sw off", d, 32'h2);
        u_host.reg_wr(ADDR_STAT, 32'h2);
        repeat (3) @(posedge clk);
        check("int clr", {31'h0, int_oe}, 32'h0);
        check("int level", {31'h0, int_pin}, 32'h0);
        stop_test();
    end
endmodule : test_light_sensor_control_irq
